// ### wdf_fifo.sv
// write-data channel fifo: stores beats from the master, replays them to the slave
// assumes one clock, synchronous reset, peer keeps valid/ready handshakes
// Overview of operation
// - write ready high exactly when space remains
// - downstream fields come from stored word
// - id tag forwarded unchanged with its beat
// - data width 8 to 512, both ports
// - one strobe bit per data byte
// - strobe bit 7 covers top byte at 64
// - last flag kept with each stored beat
// - valid high only while a beat presented
// - slave ready paces reads from the fifo
// - full threshold taken while reset asserted
// - empty threshold taken while reset asserted
// - full flag high when count at or above threshold
// - empty flag high when count at or under threshold
`timescale 1ns/1ns
`include "wdf_map.svh"
module wdf_fifo #(
  parameter int DW = `WDF_DATA_W,
  parameter int IW = `WDF_ID_W,
  parameter int UW = `WDF_USER_W,
  parameter int AW = `WDF_ADDR_W
) (
  input  wire logic   i_ref_clk,
  input  wire logic   i_rst,
  wdf_if.fifo_mp      bus,
  output logic [AW:0] o_data_count
);

  localparam int SW       = DW / `WDF_LANE_W;
  localparam int WW       = IW + UW + 1 + SW + DW;
  localparam int DEPTH    = 1 << AW;
  localparam int STRB_LSB = DW;
  localparam int LAST_BIT = DW + SW;
  localparam int USER_LSB = DW + SW + 1;
  localparam int ID_LSB   = DW + SW + 1 + UW;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [WW-1:0] mem [DEPTH];

  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   mem_cnt_reg;
  logic [AW:0]   mem_cnt_next;
  logic [AW:0]   count_reg;
  logic [AW:0]   count_next;
  logic          out_vld_reg;
  logic          out_vld_next;
  logic [WW-1:0] out_word_reg;
  logic [WW-1:0] out_word_next;
  logic          pf_reg;
  logic          pf_next;
  logic          pe_reg;
  logic          pe_next;
  logic [AW-1:0] full_th_reg;
  logic [AW-1:0] full_th_next;
  logic [AW-1:0] empty_th_reg;
  logic [AW-1:0] empty_th_next;
  logic          push;
  logic          pop_out;
  logic          load;
  logic [WW-1:0] in_word;

  // stored word layout: id, user, last, strobes, data (lane n = bits 8n+7:8n)
  assign in_word = {bus.s_wid, bus.s_wuser, bus.s_wlast, bus.s_wstrb, bus.s_wdata};

  assign bus.s_wready = (mem_cnt_reg != DEPTH_C);
  assign push         = bus.s_wvalid && bus.s_wready;
  assign pop_out      = out_vld_reg && bus.m_wready;
  assign load         = (mem_cnt_reg != '0) && (!out_vld_reg || pop_out);

  // array pointers, one step per accepted write beat and one per output-stage load
  wdf_ptr #(
    .AW (AW)
  ) i_wr_ptr (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_step    (push),
    .o_ptr     (wr_ptr)
  );

  wdf_ptr #(
    .AW (AW)
  ) i_rd_ptr (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_step    (load),
    .o_ptr     (rd_ptr)
  );

  // output stage: refilled from the array whenever it is empty or being emptied
  always_comb begin
    out_vld_next  = out_vld_reg;
    out_word_next = out_word_reg;
    if (load) begin
      out_vld_next  = 1'b1;
      out_word_next = mem[rd_ptr];
    end else if (pop_out) begin
      out_vld_next = 1'b0;
    end
    if (i_rst) begin
      out_vld_next  = `WDF_VLD_RST;
      out_word_next = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    out_vld_reg  <= out_vld_next;
    out_word_reg <= out_word_next;
  end

  // array words alone gate write ready; array plus output stage feed the flags
  always_comb begin
    mem_cnt_next = mem_cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    count_next   = mem_cnt_next + {{AW{1'b0}}, out_vld_next};
    if (i_rst) begin
      mem_cnt_next = '0;
      count_next   = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    mem_cnt_reg <= mem_cnt_next;
    count_reg   <= count_next;
  end

  // flags registered on the same edge as the count they describe
  always_comb begin
    pf_next = (count_next >= {1'b0, full_th_reg});
    pe_next = (count_next <= {1'b0, empty_th_reg});
    if (i_rst) begin
      pf_next = `WDF_PF_RST;
      pe_next = `WDF_PE_RST;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    pf_reg <= pf_next;
    pe_reg <= pe_next;
  end

  // thresholds sampled only under reset, so they never move under a live count
  always_comb begin
    full_th_next  = full_th_reg;
    empty_th_next = empty_th_reg;
    if (i_rst) begin
      full_th_next  = bus.prog_full_thresh;
      empty_th_next = bus.prog_empty_thresh;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    full_th_reg  <= full_th_next;
    empty_th_reg <= empty_th_next;
  end

  // storage array, written only on an accepted beat
  always_ff @(posedge i_ref_clk) begin
    if (push && !i_rst) begin
      mem[wr_ptr] <= in_word;
    end
  end

  // unpack the presented word onto the downstream channel
  assign bus.m_wdata  = out_word_reg[DW-1:0];
  assign bus.m_wstrb  = out_word_reg[STRB_LSB +: SW];
  assign bus.m_wlast  = out_word_reg[LAST_BIT];
  assign bus.m_wuser  = out_word_reg[USER_LSB +: UW];
  assign bus.m_wid    = out_word_reg[ID_LSB +: IW];
  assign bus.m_wvalid = out_vld_reg;
  assign bus.prog_full  = pf_reg;
  assign bus.prog_empty = pe_reg;
  assign o_data_count   = count_reg;

endmodule // wdf_fifo

// wrapping pointer into the storage array
module wdf_ptr #(
  parameter int AW = `WDF_ADDR_W
) (
  input  wire logic     i_ref_clk,
  input  wire logic     i_rst,
  input  wire logic     i_step,
  output logic [AW-1:0] o_ptr
);

  logic [AW-1:0] ptr_reg;
  logic [AW-1:0] ptr_next;

  always_comb begin
    ptr_next = ptr_reg;
    if (i_step) begin
      ptr_next = ptr_reg + 1'b1;
    end
    if (i_rst) begin
      ptr_next = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    ptr_reg <= ptr_next;
  end

  assign o_ptr = ptr_reg;

endmodule // wdf_ptr

// ### wdf_map.svh
// default widths, lane width and reset values of the write-data channel fifo
// assumes inclusion by bare name from every file that needs the constants
`ifndef WDF_MAP_SVH
`define WDF_MAP_SVH

`define WDF_DATA_W       64
`define WDF_ID_W         4
`define WDF_USER_W       1
`define WDF_ADDR_W       4
`define WDF_LANE_W       8
`define WDF_PF_RST       1'b0
`define WDF_PE_RST       1'b1
`define WDF_VLD_RST      1'b0

`endif

// ### wdf_pkg.sv
// types used by the receive buffer of the write-data channel fifo's peer
// assumes wdf_map.svh is compiled alongside
package wdf_pkg;

  typedef enum logic [1:0] {
    wdf_fill_empty,
    wdf_fill_one,
    wdf_fill_two
  } wdf_fill_t;

endpackage

// ### wdf_if.sv
// write-data channel between the fifo and its upstream master / downstream slave
// assumes both ends run on the same clock
`timescale 1ns/1ns
`include "wdf_map.svh"
interface wdf_if #(
  parameter int DW = `WDF_DATA_W,
  parameter int IW = `WDF_ID_W,
  parameter int UW = `WDF_USER_W,
  parameter int AW = `WDF_ADDR_W
);
  logic [IW-1:0]   s_wid;
  logic [DW-1:0]   s_wdata;
  logic [DW/8-1:0] s_wstrb;
  logic            s_wlast;
  logic [UW-1:0]   s_wuser;
  logic            s_wvalid;
  logic            s_wready;
  logic [IW-1:0]   m_wid;
  logic [DW-1:0]   m_wdata;
  logic [DW/8-1:0] m_wstrb;
  logic            m_wlast;
  logic [UW-1:0]   m_wuser;
  logic            m_wvalid;
  logic            m_wready;
  logic [AW-1:0]   prog_full_thresh;
  logic [AW-1:0]   prog_empty_thresh;
  logic            prog_full;
  logic            prog_empty;

  modport fifo_mp (
    input  s_wid, s_wdata, s_wstrb, s_wlast, s_wuser, s_wvalid,
    output s_wready,
    output m_wid, m_wdata, m_wstrb, m_wlast, m_wuser, m_wvalid,
    input  m_wready,
    input  prog_full_thresh, prog_empty_thresh,
    output prog_full, prog_empty
  );

  modport peer_mp (
    output s_wid, s_wdata, s_wstrb, s_wlast, s_wuser, s_wvalid,
    input  s_wready,
    input  m_wid, m_wdata, m_wstrb, m_wlast, m_wuser, m_wvalid,
    output m_wready,
    output prog_full_thresh, prog_empty_thresh,
    input  prog_full, prog_empty
  );
endinterface

// ### wdf_peer.sv
// far end of the write-data fifo: upstream master stage and downstream slave stage
// assumes one clock shared with the fifo, synchronous reset
`timescale 1ns/1ns
`include "wdf_map.svh"
module wdf_peer #(
  parameter int DW = `WDF_DATA_W,
  parameter int IW = `WDF_ID_W,
  parameter int UW = `WDF_USER_W,
  parameter int AW = `WDF_ADDR_W
) (
  input  wire logic            i_ref_clk,
  input  wire logic            i_rst,
  wdf_if.peer_mp               bus,
  input  wire logic            i_tx_valid,
  output logic                 o_tx_ready,
  input  wire logic [IW-1:0]   i_tx_id,
  input  wire logic [DW-1:0]   i_tx_data,
  input  wire logic [DW/8-1:0] i_tx_strb,
  input  wire logic            i_tx_last,
  input  wire logic [UW-1:0]   i_tx_user,
  output logic                 o_rx_valid,
  input  wire logic            i_rx_ready,
  output logic [IW-1:0]        o_rx_id,
  output logic [DW-1:0]        o_rx_data,
  output logic [DW/8-1:0]      o_rx_strb,
  output logic                 o_rx_last,
  output logic [UW-1:0]        o_rx_user,
  input  wire logic [AW-1:0]   i_full_thresh,
  input  wire logic [AW-1:0]   i_empty_thresh,
  output logic                 o_prog_full,
  output logic                 o_prog_empty
);

  localparam int WW = IW + UW + 1 + DW / `WDF_LANE_W + DW;

  logic               tx_vld_reg;
  logic               tx_vld_next;
  logic [WW-1:0]      tx_word_reg;
  logic [WW-1:0]      tx_word_next;
  logic [AW-1:0]      fth_reg;
  logic [AW-1:0]      fth_next;
  logic [AW-1:0]      eth_reg;
  logic [AW-1:0]      eth_next;
  wdf_pkg::wdf_fill_t fill_reg;
  wdf_pkg::wdf_fill_t fill_next;
  logic [WW-1:0]      s0_reg;
  logic [WW-1:0]      s0_next;
  logic [WW-1:0]      s1_reg;
  logic [WW-1:0]      s1_next;
  logic               rx_in;
  logic               rx_out;
  logic [WW-1:0]      rx_word;

  // master stage: holds a beat until the fifo takes it
  assign o_tx_ready = !tx_vld_reg || bus.s_wready;
  assign rx_word = {bus.m_wid, bus.m_wuser, bus.m_wlast, bus.m_wstrb, bus.m_wdata};
  assign rx_in   = bus.m_wvalid && bus.m_wready;
  assign rx_out  = o_rx_valid && i_rx_ready;

  always_comb begin
    tx_vld_next  = tx_vld_reg;
    tx_word_next = tx_word_reg;
    if (i_tx_valid && o_tx_ready) begin
      tx_vld_next  = 1'b1;
      tx_word_next = {i_tx_id, i_tx_user, i_tx_last, i_tx_strb, i_tx_data};
    end else if (bus.s_wready) begin
      tx_vld_next = 1'b0;
    end
    fth_next = fth_reg;
    eth_next = eth_reg;
    if (i_rst) begin
      tx_vld_next  = `WDF_VLD_RST;
      tx_word_next = '0;
      fth_next     = i_full_thresh;
      eth_next     = i_empty_thresh;
    end
  end

  // two-entry receive buffer: s0 is the head shown to the user
  always_comb begin
    fill_next = fill_reg;
    s0_next   = s0_reg;
    s1_next   = s1_reg;
    case (fill_reg)
      wdf_pkg::wdf_fill_empty: begin
        if (rx_in) begin
          s0_next   = rx_word;
          fill_next = wdf_pkg::wdf_fill_one;
        end
      end
      wdf_pkg::wdf_fill_one: begin
        if (rx_in && rx_out) begin
          s0_next = rx_word;
        end else if (rx_in) begin
          s1_next   = rx_word;
          fill_next = wdf_pkg::wdf_fill_two;
        end else if (rx_out) begin
          fill_next = wdf_pkg::wdf_fill_empty;
        end
      end
      wdf_pkg::wdf_fill_two: begin
        if (rx_out) begin
          s0_next   = s1_reg;
          fill_next = wdf_pkg::wdf_fill_one;
        end
      end
      default: begin
        fill_next = wdf_pkg::wdf_fill_empty;
      end
    endcase
    if (i_rst) begin
      fill_next = wdf_pkg::wdf_fill_empty;
      s0_next   = '0;
      s1_next   = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    tx_vld_reg  <= tx_vld_next;
    tx_word_reg <= tx_word_next;
    fth_reg     <= fth_next;
    eth_reg     <= eth_next;
    fill_reg    <= fill_next;
    s0_reg      <= s0_next;
    s1_reg      <= s1_next;
  end

  assign {bus.s_wid, bus.s_wuser, bus.s_wlast, bus.s_wstrb, bus.s_wdata} = tx_word_reg;
  assign bus.s_wvalid = tx_vld_reg;
  assign bus.m_wready = (fill_reg != wdf_pkg::wdf_fill_two);
  assign bus.prog_full_thresh  = fth_reg;
  assign bus.prog_empty_thresh = eth_reg;
  assign o_rx_valid = (fill_reg != wdf_pkg::wdf_fill_empty);
  assign {o_rx_id, o_rx_user, o_rx_last, o_rx_strb, o_rx_data} = s0_reg;
  assign o_prog_full  = bus.prog_full;
  assign o_prog_empty = bus.prog_empty;

endmodule // wdf_peer

// ### wdf_properties.sv
// concurrent checks on the write-data channel between the fifo and its peer
// assumes plain interface signals, one clock, synchronous active-high reset
`timescale 1ns/1ns
module wdf_properties #(
  parameter int DW = 64,
  parameter int IW = 4,
  parameter int UW = 1,
  parameter int AW = 4
) (
  input wire logic            i_ref_clk,
  input wire logic            i_rst,
  input wire logic [DW-1:0]   s_wdata,
  input wire logic            s_wvalid,
  input wire logic            s_wready,
  input wire logic [IW-1:0]   m_wid,
  input wire logic [DW-1:0]   m_wdata,
  input wire logic [DW/8-1:0] m_wstrb,
  input wire logic            m_wlast,
  input wire logic [UW-1:0]   m_wuser,
  input wire logic            m_wvalid,
  input wire logic            m_wready,
  input wire logic [AW-1:0]   prog_full_thresh,
  input wire logic [AW-1:0]   prog_empty_thresh,
  input wire logic            prog_full,
  input wire logic            prog_empty
);
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;

  // words held by the fifo, output stage included
  always_comb begin
    cnt_next = cnt_reg;
    if (s_wvalid && s_wready) cnt_next = cnt_next + (AW+1)'(1);
    if (m_wvalid && m_wready) cnt_next = cnt_next - (AW+1)'(1);
    if (i_rst) cnt_next = '0;
  end

  always_ff @(posedge i_ref_clk) begin
    cnt_reg <= cnt_next;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence first_beat_s;
    s_wvalid && s_wready && cnt_reg == 0;
  endsequence
  sequence load_out_s;
    !m_wvalid ##1 m_wvalid;
  endsequence

  fill_latency_a: assert property (first_beat_s |-> ##1 load_out_s)
    else $error("output beat not presented two cycles after first write");
  hold_out_a: assert property (m_wvalid && !m_wready |=> m_wvalid &&
    $stable({m_wid, m_wdata, m_wstrb, m_wlast, m_wuser}))
    else $error("presented beat changed before acceptance");
  valid_count_a: assert property (m_wvalid |-> cnt_reg != 0)
    else $error("valid raised with no stored beat");
  full_refuse_a: assert property (cnt_reg >= 17 |-> !s_wready)
    else $error("write ready high while full");
  ready_space_a: assert property (!s_wready |-> cnt_reg >= 16)
    else $error("write ready low with space left");
  ready_back_a: assert property (!s_wready && m_wvalid && m_wready |-> ##[1:2] s_wready)
    else $error("write ready not restored after a read");
  pfull_level_a: assert property (prog_full == (cnt_reg >= prog_full_thresh))
    else $error("programmable full flag disagrees with count");
  pempty_level_a: assert property (prog_empty == (cnt_reg <= prog_empty_thresh))
    else $error("programmable empty flag disagrees with count");
  src_hold_a: assert property (s_wvalid && !s_wready |=> s_wvalid && $stable(s_wdata))
    else $error("upstream beat changed before acceptance");
  reset_vals_a: assert property (disable iff (1'b0) i_rst |=>
    !m_wvalid && !prog_full && prog_empty && s_wready)
    else $error("outputs not at reset values");
endmodule // wdf_properties

// ### test_axi_write_data_channel_fifo.sv
// self-checking bench: fifo and peer joined by the channel interface
// assumes default widths, 50 ns clock, synchronous active-high reset
`timescale 1ns/1ns
module test_axi_write_data_channel_fifo;
  logic        i_ref_clk = 1'b0;
  logic        i_rst, i_tx_valid, i_tx_last, i_rx_ready, o_tx_ready, o_rx_valid;
  logic        o_rx_last, o_prog_full, o_prog_empty;
  logic [3:0]  i_tx_id, o_rx_id, i_full_thresh, i_empty_thresh;
  logic [63:0] i_tx_data, o_rx_data;
  logic [7:0]  i_tx_strb, o_rx_strb;
  logic [0:0]  i_tx_user, o_rx_user;
  logic [4:0]  data_count;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          acc;
  localparam logic [77:0] rows [4] = '{
    {4'h1, 64'h0123456789abcdef, 8'h01, 1'b0, 1'b1},
    {4'h7, 64'hfedcba9876543210, 8'h80, 1'b0, 1'b0},
    {4'ha, 64'hffffffffffffffff, 8'hff, 1'b0, 1'b1},
    {4'hf, 64'h00000000000000ff, 8'h00, 1'b1, 1'b0}};

  wdf_if w_bus ();
  wdf_fifo i_wdf_fifo (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(w_bus),
    .o_data_count(data_count));
  wdf_peer i_wdf_peer (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(w_bus),
    .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .i_tx_id(i_tx_id),
    .i_tx_data(i_tx_data), .i_tx_strb(i_tx_strb), .i_tx_last(i_tx_last),
    .i_tx_user(i_tx_user), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
    .o_rx_id(o_rx_id), .o_rx_data(o_rx_data), .o_rx_strb(o_rx_strb),
    .o_rx_last(o_rx_last), .o_rx_user(o_rx_user), .i_full_thresh(i_full_thresh),
    .i_empty_thresh(i_empty_thresh), .o_prog_full(o_prog_full),
    .o_prog_empty(o_prog_empty));
  wdf_properties i_wdf_properties (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .s_wdata(w_bus.s_wdata), .s_wvalid(w_bus.s_wvalid), .s_wready(w_bus.s_wready),
    .m_wid(w_bus.m_wid), .m_wdata(w_bus.m_wdata), .m_wstrb(w_bus.m_wstrb),
    .m_wlast(w_bus.m_wlast), .m_wuser(w_bus.m_wuser), .m_wvalid(w_bus.m_wvalid),
    .m_wready(w_bus.m_wready), .prog_full_thresh(w_bus.prog_full_thresh),
    .prog_empty_thresh(w_bus.prog_empty_thresh), .prog_full(w_bus.prog_full),
    .prog_empty(w_bus.prog_empty));

  always #25 i_ref_clk = ~i_ref_clk;

  task automatic print_verdict;
    $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict;
    end
  end

  task automatic check(input logic [77:0] seen, input logic [77:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [77:0] wd(input int k);
    return {k[3:0], {8{k[7:0]}}, ~k[7:0], k[0], k[1]};
  endfunction

  task automatic push(input logic [77:0] w);
    int n;
    n = 0;
    i_tx_valid = 1'b1;
    {i_tx_id, i_tx_data, i_tx_strb, i_tx_last, i_tx_user} = w;
    do begin @(negedge i_ref_clk); n++; end while (!o_tx_ready && n < 50);
    if (!o_tx_ready) num_errors++;
    @(posedge i_ref_clk);
    #1;
  endtask

  // optional one-cycle stall before taking the next beat
  task automatic pop(input logic [77:0] w, input bit stall);
    int n;
    n = 0;
    if (stall) begin
      i_rx_ready = 1'b0;
      @(posedge i_ref_clk);
      #1;
    end
    i_rx_ready = 1'b1;
    do begin @(negedge i_ref_clk); n++; end while (!o_rx_valid && n < 50);
    if (!o_rx_valid) num_errors++;
    check({o_rx_id, o_rx_data, o_rx_strb, o_rx_last, o_rx_user}, w);
    @(posedge i_ref_clk);
    #1;
  endtask

  initial begin
    i_rst = 1'b1;
    i_tx_valid = 1'b0;
    {i_tx_id, i_tx_data, i_tx_strb, i_tx_last, i_tx_user} = '0;
    i_rx_ready = 1'b0;
    i_full_thresh = 4'h9;
    i_empty_thresh = 4'h3;
    repeat (16) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    check({74'h0, o_prog_full, o_prog_empty, o_rx_valid, o_tx_ready}, 78'h5);
    foreach (rows[r]) push(rows[r]);
    i_tx_valid = 1'b0;
    foreach (rows[r]) pop(rows[r], 1'b0);
    i_rx_ready = 1'b0;
    acc = 0;
    i_tx_valid = 1'b1;
    for (int k = 0; k < 30; k++) begin
      {i_tx_id, i_tx_data, i_tx_strb, i_tx_last, i_tx_user} = wd(acc);
      @(negedge i_ref_clk);
      if (o_tx_ready) acc++;
      @(posedge i_ref_clk);
      #1;
    end
    i_tx_valid = 1'b0;
    check(78'(acc), 78'h14);
    check({71'h0, w_bus.s_wready, o_prog_full, data_count}, 78'h31);
    for (int k = 0; k < 20; k++) pop(wd(k), k[0]);
    i_rx_ready = 1'b0;
    check({76'h0, o_prog_full, o_prog_empty}, 78'h1);
    // second reset with new thresholds, then a partial fill
    i_full_thresh = 4'h2;
    i_empty_thresh = 4'h0;
    i_rst = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    check({74'h0, o_prog_full, o_prog_empty, o_rx_valid, o_tx_ready}, 78'h5);
    for (int k = 0; k < 5; k++) push(wd(k + 32));
    i_tx_valid = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1;
    check({71'h0, o_prog_full, o_prog_empty, data_count}, 78'h43);
    for (int k = 0; k < 5; k++) pop(wd(k + 32), 1'b0);
    i_rx_ready = 1'b0;
    check({76'h0, o_prog_full, o_prog_empty}, 78'h1);
    print_verdict;
  end
endmodule // test_axi_write_data_channel_fifo
